// file: rtl/modem_tx_config_and_dsp_ram_port.sv
`timescale 1ns/10ps
// Function
// - Parallel mode bit picks host buffer data, else serial pin data.
// - Freeze bit stops receiver timing recovery updates while set.
// - Clock select: internal, disabled, slave to receive clock, or external.
// - External clock code: terminal drives clock in, device echoes it out.
// - Stuffed parity with eight bits sends ninth-bit control as parity.
// - Squelch bit set means no transmitted energy at all.
// - Voice bit in tone configuration sends buffer samples straight to DAC.
// - Ones flag set while unscrambled ones seen, cleared when they end.
// - Speaker field: off, 0 dB, 6 dB, 12 dB attenuation.
// - Half-duplex receive ignores speaker field changes.
// - Word size field gives five to eight data bits.
// - X go bit performs one access, self-clears, sets new-status flag.
// - X coefficient bit selects coefficient or data RAM; address register locates.
// - X continuous read ignores go and write, reads every sample period.
// - X write bit writes data pair to RAM, else reads RAM.
// - X data word is 16 bits, low byte then high byte.
// - Y go bit performs one access, self-clears, sets new-status flag.
// - Y coefficient bit selects RAM section; data via Y byte pair.
// - Y continuous read ignores go and write, reads every sample period.
// - Y write bit writes data pair to RAM, else reads RAM.
module modem_tx_config_and_dsp_ram_port #(
  parameter int ADDR_W = 8,
  parameter int unsigned SAMPLE_CYCLES = modem_cfg_pkg::CLK_HZ / modem_cfg_pkg::SAMPLE_HZ,
  parameter int unsigned BIT_CYCLES = modem_cfg_pkg::CLK_HZ / modem_cfg_pkg::BAUD_HZ,
  parameter int unsigned CLK_HALF_CYCLES = modem_cfg_pkg::CLK_HZ / (2 * modem_cfg_pkg::BAUD_HZ)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Host interface memory bus
  input wire logic [4:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic host_wr,
  input wire logic host_rd,
  output logic [7:0] host_rdata,
  // Serial terminal link
  input wire logic ext_tx_clock_in,
  input wire logic tx_data_in,
  output logic tx_clock_out,
  output logic rx_clock_out_n,
  // Transmit path
  output logic tx_line_bit,
  output logic [7:0] dac_sample_out,
  output logic tx_energy_en,
  // Receiver and speaker hooks
  input wire logic ones_detect_in,
  input wire logic hdx_rx_mode,
  output logic timing_recovery_freeze,
  output logic speaker_on,
  output logic [3:0] speaker_atten_db
);
  import modem_cfg_pkg::*;

  localparam int DEPTH = 2 ** ADDR_W;

  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_state_e;

  function automatic logic is_mapped(input logic [4:0] a);
    return a == OFS_TONE_CTL || a == OFS_CHAR_CTL || a == OFS_MODE_CTL
        || a == OFS_DET_STAT || a == OFS_TX_BUF || a == OFS_TX_NINTH
        || a == OFS_CLK_VOL || a == OFS_CONFIG || a == OFS_NEW_STATUS_FLAG
        || (a >= OFS_Y_DATA_LO && a <= OFS_X_CTL);
  endfunction : is_mapped

  function automatic logic [7:0] word_mask(input logic [1:0] async_word_size);
    return 8'hFF >> (2'h3 - async_word_size);
  endfunction : word_mask

  // ----------------------------------------------------------------
  // Interface memory
  // ----------------------------------------------------------------
  logic [7:0] cfg_q [32];
  logic [7:0] cfg_d [32];
  logic [7:0] rdata_q;
  logic [15:0] ram_q [2][2][DEPTH];
  logic sample_tick;
  logic [CNT_W-1:0] sample_cnt_q;

  wire host_we = ce && host_wr && is_mapped(host_addr);
  wire tx_buf_we = host_we && host_addr == OFS_TX_BUF;

  logic acc_done [2];
  logic rd_load [2];
  logic ram_we [2];
  logic [ADDR_W-1:0] port_addr [2];
  logic port_coef [2];
  logic [15:0] port_wr_word [2];
  logic [15:0] port_rd_word [2];

  for (genvar p = 0; p < 2; p++)
  begin : g_port
    wire go = cfg_q[PORT_CTL_OFS[p]][BIT_GO];
    wire cont = cfg_q[PORT_CTL_OFS[p]][BIT_CONT];
    wire wsel = cfg_q[PORT_CTL_OFS[p]][BIT_WSEL];
    // Continuous read masks the go and write bits
    assign acc_done[p] = go && !cont;
    assign rd_load[p] = (acc_done[p] && !wsel) || (cont && sample_tick);
    assign ram_we[p] = ce && acc_done[p] && wsel;
    assign port_coef[p] = cfg_q[PORT_CTL_OFS[p]][BIT_COEF];
    assign port_addr[p] = cfg_q[PORT_ADDR_OFS[p]][ADDR_W-1:0];
    assign port_wr_word[p] = {cfg_q[PORT_HI_OFS[p]], cfg_q[PORT_LO_OFS[p]]};
    assign port_rd_word[p] = ram_q[p][port_coef[p]][port_addr[p]];
  end

  always_comb
  begin
    cfg_d = cfg_q;
    for (int p = 0; p < 2; p++)
    begin
      if (acc_done[p])
        cfg_d[PORT_CTL_OFS[p]][BIT_GO] = 1'b0;
    end
    // A host write after the self-clear lets a fresh go survive
    if (host_we && host_addr == OFS_NEW_STATUS_FLAG)
      cfg_d[OFS_NEW_STATUS_FLAG] = cfg_q[OFS_NEW_STATUS_FLAG] & host_wdata;
    else if (host_we && host_addr != OFS_DET_STAT)
      cfg_d[host_addr] = host_wdata;
    for (int p = 0; p < 2; p++)
    begin
      if (rd_load[p])
        {cfg_d[PORT_HI_OFS[p]], cfg_d[PORT_LO_OFS[p]]} = port_rd_word[p];
    end
    // Completion beats a simultaneous clear by the host
    if (acc_done[0] || acc_done[1])
      cfg_d[OFS_NEW_STATUS_FLAG][BIT_NEW_STATUS_FLAG] = 1'b1;
    cfg_d[OFS_DET_STAT][BIT_ONES] = ones_detect_in;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 32; i++)
        cfg_q[i] <= RST_BYTE;
    end
    else if (ce)
    begin
      cfg_q <= cfg_d;
    end
  end

  // RAM holds no control state, so it is left without reset
  always_ff @(posedge clk)
  begin
    for (int p = 0; p < 2; p++)
    begin
      if (ram_we[p])
        ram_q[p][port_coef[p]][port_addr[p]] <= port_wr_word[p];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= RST_BYTE;
    else if (ce && host_rd)
      rdata_q <= is_mapped(host_addr) ? cfg_q[host_addr] : RST_BYTE;
  end

  assign host_rdata = rdata_q;

  // ----------------------------------------------------------------
  // Sample period
  // ----------------------------------------------------------------
  assign sample_tick = sample_cnt_q == CNT_W'(SAMPLE_CYCLES - 1);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sample_cnt_q <= '0;
    else if (ce)
      sample_cnt_q <= sample_tick ? '0 : sample_cnt_q + 1'b1;
  end

  // ----------------------------------------------------------------
  // Link domain: serial byte gatherer on the terminal's clock
  // ----------------------------------------------------------------
  logic [7:0] lk_shift_q;
  logic [7:0] lk_byte_q;
  logic [2:0] lk_cnt_q;
  logic lk_tog_q;

  always_ff @(posedge ext_tx_clock_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lk_shift_q <= RST_BYTE;
      lk_byte_q <= RST_BYTE;
      lk_cnt_q <= '0;
      lk_tog_q <= 1'b0;
    end
    else
    begin
      lk_shift_q <= {tx_data_in, lk_shift_q[7:1]};
      lk_cnt_q <= lk_cnt_q + 1'b1;
      if (&lk_cnt_q)
      begin
        lk_byte_q <= {tx_data_in, lk_shift_q[7:1]};
        lk_tog_q <= ~lk_tog_q;
      end
    end
  end

  // Toggle crossing; the byte holds for eight link clocks after it
  logic [2:0] tog_sync_q;
  logic [1:0] xclk_sync_q;
  logic [7:0] ser_byte_q;
  logic ser_pend_q;
  wire ser_new = tog_sync_q[2] ^ tog_sync_q[1];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tog_sync_q <= '0;
      xclk_sync_q <= '0;
    end
    else if (ce)
    begin
      tog_sync_q <= {tog_sync_q[1:0], lk_tog_q};
      xclk_sync_q <= {xclk_sync_q[0], ext_tx_clock_in};
    end
  end

  // ----------------------------------------------------------------
  // Data clock outputs
  // ----------------------------------------------------------------
  clk_src_e clk_sel;
  logic [CNT_W-1:0] half_cnt_q;
  logic int_ph_q;
  logic tx_clk_q;
  logic rx_clk_n_q;
  assign clk_sel = clk_src_e'(cfg_q[OFS_CLK_VOL][LSB_CLKSEL +: 2]);
  wire half_tick = half_cnt_q == CNT_W'(CLK_HALF_CYCLES - 1);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      half_cnt_q <= '0;
      int_ph_q <= 1'b0;
    end
    else if (ce)
    begin
      half_cnt_q <= half_tick ? '0 : half_cnt_q + 1'b1;
      int_ph_q <= int_ph_q ^ half_tick;
    end
  end

  logic tx_clk_d;
  logic rx_clk_n_d;
  always_comb
  begin
    unique case (clk_sel)
      CLK_INTERNAL:
      begin
        tx_clk_d = int_ph_q;
        rx_clk_n_d = ~int_ph_q;
      end
      CLK_DISABLED:
      begin
        tx_clk_d = 1'b0;
        rx_clk_n_d = 1'b1;
      end
      CLK_SLAVE:
      begin
        tx_clk_d = ~rx_clk_n_q;
        rx_clk_n_d = ~int_ph_q;
      end
      CLK_EXTERNAL:
      begin
        tx_clk_d = xclk_sync_q[1];
        rx_clk_n_d = ~int_ph_q;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_clk_q <= 1'b0;
      rx_clk_n_q <= 1'b1;
    end
    else if (ce)
    begin
      tx_clk_q <= tx_clk_d;
      rx_clk_n_q <= rx_clk_n_d;
    end
  end

  assign tx_clock_out = tx_clk_q;
  assign rx_clock_out_n = rx_clk_n_q;

  // ----------------------------------------------------------------
  // Character transmitter
  // ----------------------------------------------------------------
  tx_state_e tx_state_q;
  logic [CNT_W-1:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [3:0] bit_idx_q;
  logic par_q;
  logic line_q;
  logic buf_full_q;
  logic [7:0] dac_q;
  logic [1:0] spk_q;

  wire [7:0] char_ctl = cfg_q[OFS_CHAR_CTL];
  wire [1:0] async_word_size = char_ctl[LSB_ASYNC_WORD_SIZE +: 2];
  wire [1:0] parity_kind_sel = char_ctl[LSB_PARITY_KIND_SEL +: 2];
  wire [3:0] n_bits = MIN_WORD_BITS + {2'h0, async_word_size};
  wire parallel_mode = cfg_q[OFS_MODE_CTL][BIT_PARMODE];
  wire voice_mode = cfg_q[OFS_TONE_CTL][BIT_VOICE] && cfg_q[OFS_CONFIG] == CONFIG_TONE;
  wire squelch = cfg_q[OFS_TONE_CTL][BIT_SQUELCH];
  wire src_ready = parallel_mode ? buf_full_q : ser_pend_q;
  wire [7:0] src_byte = parallel_mode ? cfg_q[OFS_TX_BUF] : ser_byte_q;
  wire bit_end = bit_cnt_q == CNT_W'(BIT_CYCLES - 1);
  wire load = ce && tx_state_q == TX_IDLE && src_ready && !voice_mode;
  wire stuffed = parity_kind_sel == PAR_STUFF && async_word_size == 2'h3;
  wire data_par = ^(src_byte & word_mask(async_word_size));
  wire par_bit = stuffed ? cfg_q[OFS_TX_NINTH][BIT_NINTH]
      : (parity_kind_sel == PAR_ODD ? ~data_par : (parity_kind_sel == PAR_EVEN ? data_par : 1'b0));

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      buf_full_q <= 1'b0;
      ser_pend_q <= 1'b0;
      ser_byte_q <= RST_BYTE;
    end
    else if (ce)
    begin
      // A fresh arrival in the load cycle wins over the clear
      buf_full_q <= (tx_buf_we && !voice_mode) || (buf_full_q && !(load && parallel_mode));
      ser_pend_q <= ser_new || (ser_pend_q && !(load && !parallel_mode));
      if (ser_new)
        ser_byte_q <= lk_byte_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_state_q <= TX_IDLE;
      bit_cnt_q <= '0;
      shift_q <= RST_BYTE;
      bit_idx_q <= '0;
      par_q <= 1'b0;
      line_q <= 1'b1;
    end
    else if (ce)
    begin
      bit_cnt_q <= (load || bit_end) ? '0 : bit_cnt_q + 1'b1;
      unique case (tx_state_q)
        TX_IDLE:
        begin
          line_q <= 1'b1;
          if (load)
          begin
            shift_q <= src_byte;
            par_q <= par_bit;
            line_q <= 1'b0;
            tx_state_q <= TX_START;
          end
        end
        TX_START:
        begin
          if (bit_end)
          begin
            line_q <= shift_q[0];
            shift_q <= shift_q >> 1;
            bit_idx_q <= 4'h1;
            tx_state_q <= TX_DATA;
          end
        end
        TX_DATA:
        begin
          if (bit_end && bit_idx_q != n_bits)
          begin
            line_q <= shift_q[0];
            shift_q <= shift_q >> 1;
            bit_idx_q <= bit_idx_q + 1'b1;
          end
          else if (bit_end)
          begin
            line_q <= char_ctl[BIT_PEN] ? par_q : 1'b1;
            bit_idx_q <= '0;
            tx_state_q <= char_ctl[BIT_PEN] ? TX_PARITY : TX_STOP;
          end
        end
        TX_PARITY:
        begin
          if (bit_end)
          begin
            line_q <= 1'b1;
            tx_state_q <= TX_STOP;
          end
        end
        TX_STOP:
        begin
          if (bit_end)
          begin
            bit_idx_q <= bit_idx_q + 1'b1;
            if (bit_idx_q == {3'h0, char_ctl[BIT_STB]})
              tx_state_q <= TX_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // DAC, squelch and speaker
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dac_q <= DAC_SILENT;
      spk_q <= VOL_OFF;
    end
    else if (ce)
    begin
      if (squelch)
        dac_q <= DAC_SILENT;
      else if (voice_mode && tx_buf_we)
        dac_q <= host_wdata;
      else if (!voice_mode)
        dac_q <= line_q ? DAC_MARK : DAC_SPACE;
      if (!hdx_rx_mode)
        spk_q <= cfg_q[OFS_CLK_VOL][LSB_VOL +: 2];
    end
  end

  assign tx_line_bit = line_q;
  assign dac_sample_out = dac_q;
  assign tx_energy_en = !squelch;
  assign timing_recovery_freeze = cfg_q[OFS_MODE_CTL][BIT_FREEZE];
  assign speaker_on = spk_q != VOL_OFF;
  assign speaker_atten_db = spk_q == VOL_MID ? ATTEN_MID_DB
      : (spk_q == VOL_LOW ? ATTEN_LOW_DB : ATTEN_NONE_DB);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  x_go_done_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && acc_done[0] && !(host_we && host_addr == OFS_X_CTL)
    |=> !cfg_q[OFS_X_CTL][BIT_GO] && cfg_q[OFS_NEW_STATUS_FLAG][BIT_NEW_STATUS_FLAG])
    else $error("X access did not self-clear or flag");
  y_go_done_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && acc_done[1] && !(host_we && host_addr == OFS_Y_CTL)
    |=> !cfg_q[OFS_Y_CTL][BIT_GO] && cfg_q[OFS_NEW_STATUS_FLAG][BIT_NEW_STATUS_FLAG])
    else $error("Y access did not self-clear or flag");
  x_ram_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    ram_we[0] |=> ram_q[0][$past(port_coef[0])][$past(port_addr[0])] == $past(port_wr_word[0]))
    else $error("X RAM write lost");
  x_cont_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && cfg_q[OFS_X_CTL][BIT_CONT] && sample_tick && !host_we
    |=> {cfg_q[OFS_X_DATA_HI], cfg_q[OFS_X_DATA_LO]} == $past(port_rd_word[0]))
    else $error("X continuous read missed");
  y_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && acc_done[1] && !cfg_q[OFS_Y_CTL][BIT_WSEL] && !host_we
    |=> {cfg_q[OFS_Y_DATA_HI], cfg_q[OFS_Y_DATA_LO]} == $past(port_rd_word[1]))
    else $error("Y read did not load data pair");
  squelch_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && squelch |-> !tx_energy_en ##1 dac_sample_out == DAC_SILENT)
    else $error("Energy sent while squelched");
  clk_disabled_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && clk_sel == CLK_DISABLED)[*2] |-> !tx_clock_out && rx_clock_out_n)
    else $error("Clock outputs not disabled");
  speaker_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    hdx_rx_mode |=> $stable(speaker_atten_db) && $stable(speaker_on))
    else $error("Speaker changed in half-duplex receive");
  ones_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce |=> cfg_q[OFS_DET_STAT][BIT_ONES] == $past(ones_detect_in))
    else $error("Ones flag does not follow detector");

endmodule : modem_tx_config_and_dsp_ram_port

// file: rtl/modem_cfg_pkg.sv
package modem_cfg_pkg;

  // ----------------------------------------------------------------
  // Interface memory locations
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_TONE_CTL = 5'h05;
  localparam logic [4:0] OFS_CHAR_CTL = 5'h06;
  localparam logic [4:0] OFS_MODE_CTL = 5'h08;
  localparam logic [4:0] OFS_DET_STAT = 5'h0D;
  localparam logic [4:0] OFS_TX_BUF = 5'h10;
  localparam logic [4:0] OFS_TX_NINTH = 5'h11;
  localparam logic [4:0] OFS_CLK_VOL = 5'h13;
  localparam logic [4:0] OFS_CONFIG = 5'h14;
  localparam logic [4:0] OFS_Y_DATA_LO = 5'h16;
  localparam logic [4:0] OFS_Y_DATA_HI = 5'h17;
  localparam logic [4:0] OFS_X_DATA_LO = 5'h18;
  localparam logic [4:0] OFS_X_DATA_HI = 5'h19;
  localparam logic [4:0] OFS_Y_ADDR = 5'h1A;
  localparam logic [4:0] OFS_Y_CTL = 5'h1B;
  localparam logic [4:0] OFS_X_ADDR = 5'h1C;
  localparam logic [4:0] OFS_X_CTL = 5'h1D;
  localparam logic [4:0] OFS_NEW_STATUS_FLAG = 5'h1F;

  // Port 0 is X, port 1 is Y
  localparam logic [4:0] PORT_CTL_OFS [2] = '{OFS_X_CTL, OFS_Y_CTL};
  localparam logic [4:0] PORT_ADDR_OFS [2] = '{OFS_X_ADDR, OFS_Y_ADDR};
  localparam logic [4:0] PORT_LO_OFS [2] = '{OFS_X_DATA_LO, OFS_Y_DATA_LO};
  localparam logic [4:0] PORT_HI_OFS [2] = '{OFS_X_DATA_HI, OFS_Y_DATA_HI};

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_SQUELCH = 4;
  localparam int BIT_VOICE = 1;
  localparam int BIT_PARMODE = 6;
  localparam int BIT_FREEZE = 3;
  localparam int BIT_ONES = 3;
  localparam int BIT_STB = 2;
  localparam int BIT_PEN = 5;
  localparam int LSB_PARITY_KIND_SEL = 3;
  localparam int LSB_ASYNC_WORD_SIZE = 0;
  localparam int LSB_CLKSEL = 0;
  localparam int LSB_VOL = 2;
  localparam int BIT_NINTH = 0;
  localparam int BIT_GO = 7;
  localparam int BIT_CONT = 2;
  localparam int BIT_WSEL = 1;
  localparam int BIT_COEF = 0;
  localparam int BIT_NEW_STATUS_FLAG = 0;

  // ----------------------------------------------------------------
  // Codes and values
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {CLK_INTERNAL, CLK_DISABLED, CLK_SLAVE, CLK_EXTERNAL} clk_src_e;
  localparam logic [1:0] PAR_STUFF = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h1;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [1:0] VOL_OFF = 2'h0;
  localparam logic [1:0] VOL_MID = 2'h2;
  localparam logic [1:0] VOL_LOW = 2'h3;
  localparam logic [3:0] ATTEN_NONE_DB = 4'h0;
  localparam logic [3:0] ATTEN_MID_DB = 4'h6;
  localparam logic [3:0] ATTEN_LOW_DB = 4'hC;
  localparam logic [3:0] MIN_WORD_BITS = 4'h5;
  localparam logic [7:0] CONFIG_TONE = 8'h80;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] DAC_MARK = 8'h40;
  localparam logic [7:0] DAC_SPACE = 8'hC0;
  localparam logic [7:0] DAC_SILENT = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 200000000;
  localparam int unsigned SAMPLE_HZ = 9600;
  localparam int unsigned BAUD_HZ = 1200;
  localparam int CNT_W = 18;

endpackage : modem_cfg_pkg

// file: testbench/host_model.sv
`timescale 1ns/10ps
module host_model (
  // Bus
  input wire logic clk,
  input wire logic [7:0] host_rdata,
  output logic [4:0] host_addr,
  output logic [7:0] host_wdata,
  output logic host_wr,
  output logic host_rd
);
  import modem_cfg_pkg::*;
  initial
  begin
    host_addr = 5'h00;
    host_wdata = 8'h00;
    host_wr = 1'b0;
    host_rd = 1'b0;
  end
  // Data is not held after a write, so the bus shows the inverse
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    @(posedge clk);
    #1 host_wr = 1'b0;
    host_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk);
    #1 host_addr = a;
    host_rd = 1'b1;
    @(posedge clk);
    #1 host_rd = 1'b0;
    @(negedge clk);
    d = host_rdata;
  endtask : rd
  // Port registers stay untouched until the go bit drops
  task automatic ram_go(input int p, input logic [7:0] c);
    logic [7:0] s;
    wr(PORT_CTL_OFS[p], c);
    s = 8'h80;
    for (int i = 0; i < 20 && s[7]; i++)
      rd(PORT_CTL_OFS[p], s);
  endtask : ram_go
endmodule : host_model

// file: testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
  import modem_cfg_pkg::*;
  logic clk, rst_n, xclk, txd, ones, hdx, wr, rd, tclk, rclk_n, line, energy, frz, spk_on;
  logic [4:0] addr;
  logic [7:0] wdata, rdata, dac, v;
  logic [3:0] atten;
  int num_errors = 0;
  int comparisons = 0;
  localparam logic [7:0] SER = 8'hC3;

  modem_tx_config_and_dsp_ram_port #(.SAMPLE_CYCLES(16), .BIT_CYCLES(8),
    .CLK_HALF_CYCLES(4)) DUT (.clk(clk), .rst_n(rst_n), .ce(1'b1), .host_addr(addr),
    .host_wdata(wdata), .host_wr(wr), .host_rd(rd), .host_rdata(rdata),
    .ext_tx_clock_in(xclk), .tx_data_in(txd), .tx_clock_out(tclk), .rx_clock_out_n(rclk_n),
    .tx_line_bit(line), .dac_sample_out(dac), .tx_energy_en(energy), .ones_detect_in(ones),
    .hdx_rx_mode(hdx), .timing_recovery_freeze(frz), .speaker_on(spk_on),
    .speaker_atten_db(atten));
  host_model host (.clk(clk), .host_rdata(rdata), .host_addr(addr), .host_wdata(wdata),
    .host_wr(wr), .host_rd(rd));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done;
    if (num_errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done
  // Samples each line bit near its middle, start bit first
  task automatic frame(input logic [11:0] e, input int n);
    int i;
    i = 0;
    while (line !== 1'b0 && i < 400)
    begin
      @(negedge clk);
      i++;
    end
    repeat (4) @(negedge clk);
    for (i = 0; i < n; i++)
    begin
      chk({7'h00, line}, {7'h00, e[i]});
      repeat (8) @(negedge clk);
    end
  endtask : frame

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    for (int a = 24; a < 30; a++)
    begin
      host.rd(a[4:0], v);
      chk(v, RST_BYTE);
    end
    host.wr(5'h00, 8'hFF);
    host.rd(5'h00, v);
    chk(v, 8'h00);
  endtask : t_regs
  task automatic t_ram(input int p);
    host.wr(PORT_ADDR_OFS[p], 8'h3C);
    host.wr(PORT_LO_OFS[p], 8'hA5);
    host.wr(PORT_HI_OFS[p], 8'h5A);
    host.ram_go(p, 8'h82);
    host.wr(PORT_LO_OFS[p], 8'h11);
    host.wr(PORT_HI_OFS[p], 8'h22);
    host.ram_go(p, 8'h83);
    host.wr(OFS_NEW_STATUS_FLAG, 8'h00);
    host.ram_go(p, 8'h80);
    host.rd(PORT_CTL_OFS[p], v);
    chk(v, 8'h00);
    host.rd(OFS_NEW_STATUS_FLAG, v);
    chk({7'h00, v[0]}, 8'h01);
    host.rd(PORT_LO_OFS[p], v);
    chk(v, 8'hA5);
    host.rd(PORT_HI_OFS[p], v);
    chk(v, 8'h5A);
    host.ram_go(p, 8'h81);
    host.rd(PORT_HI_OFS[p], v);
    chk(v, 8'h22);
    host.wr(PORT_CTL_OFS[p], 8'h86);
    repeat (40) @(negedge clk);
    host.rd(PORT_LO_OFS[p], v);
    chk(v, 8'hA5);
    host.rd(PORT_CTL_OFS[p], v);
    chk(v, 8'h86);
    host.wr(PORT_CTL_OFS[p], 8'h00);
  endtask : t_ram
  task automatic t_clk;
    host.wr(OFS_CLK_VOL, 8'h00);
    repeat (8) @(negedge clk);
    repeat (4)
    begin
      v[0] = tclk;
      repeat (4) @(negedge clk);
      chk({7'h00, tclk}, {7'h00, ~v[0]});
      chk({7'h00, rclk_n}, {7'h00, v[0]});
    end
    host.wr(OFS_CLK_VOL, 8'h02);
    repeat (16)
    begin
      v[0] = rclk_n;
      @(negedge clk);
      chk({7'h00, tclk}, {7'h00, ~v[0]});
    end
    host.wr(OFS_CLK_VOL, 8'h01);
    repeat (2) @(negedge clk);
    chk({6'h00, tclk, rclk_n}, 8'h01);
  endtask : t_clk
  task automatic t_tx;
    host.wr(OFS_MODE_CTL, 8'h40);
    for (int w = 0; w < 4; w++)
    begin
      host.wr(OFS_CHAR_CTL, w[7:0]);
      host.wr(OFS_TX_BUF, 8'hA5);
      frame({3'b111, 8'hA5, 1'b0} | (12'hFFF << (w + 6)), w + 7);
    end
    for (int b = 0; b < 2; b++)
    begin
      host.wr(OFS_CHAR_CTL, 8'h23);
      host.wr(OFS_TX_NINTH, b[7:0]);
      host.wr(OFS_TX_BUF, 8'h5A);
      frame({2'b11, b[0], 8'h5A, 1'b0}, 11);
    end
    // Odd parity over four ones gives a one, then two stop bits
    host.wr(OFS_CHAR_CTL, 8'h2F);
    host.wr(OFS_TX_BUF, 8'h5A);
    frame({3'b111, 8'h5A, 1'b0}, 12);
  endtask : t_tx
  task automatic t_voice;
    host.wr(OFS_CONFIG, CONFIG_TONE);
    host.wr(OFS_TONE_CTL, 8'h02);
    host.wr(OFS_TX_BUF, 8'h5A);
    repeat (2) @(negedge clk);
    chk(dac, 8'h5A);
    chk({7'h00, energy}, 8'h01);
    host.wr(OFS_TONE_CTL, 8'h12);
    repeat (2) @(negedge clk);
    chk({energy, dac[6:0]}, 8'h00);
    chk(dac, DAC_SILENT);
    host.wr(OFS_TONE_CTL, 8'h00);
    host.wr(OFS_CONFIG, 8'h00);
  endtask : t_voice
  task automatic t_misc;
    for (int c = 0; c < 4; c++)
    begin
      host.wr(OFS_CLK_VOL, {4'h0, c[1:0], 2'b01});
      repeat (2) @(negedge clk);
      chk({7'h00, spk_on}, {7'h00, c != 0});
      if (c != 0)
        chk({4'h0, atten}, 8'((c - 1) * 6));
    end
    @(posedge clk);
    #1 hdx = 1'b1;
    host.wr(OFS_CLK_VOL, 8'h05);
    repeat (2) @(negedge clk);
    chk({spk_on, 3'h0, atten}, 8'h8C);
    @(posedge clk);
    #1 hdx = 1'b0;
    repeat (2) @(negedge clk);
    chk({spk_on, 3'h0, atten}, 8'h80);
    host.wr(OFS_MODE_CTL, 8'h08);
    @(negedge clk);
    chk({7'h00, frz}, 8'h01);
    @(posedge clk);
    #1 ones = 1'b1;
    host.rd(OFS_DET_STAT, v);
    chk({7'h00, v[3]}, 8'h01);
    @(posedge clk);
    #1 ones = 1'b0;
    host.wr(OFS_DET_STAT, 8'hFF);
    host.rd(OFS_DET_STAT, v);
    chk(v, 8'h00);
    host.wr(OFS_MODE_CTL, 8'h00);
    @(negedge clk);
    chk({7'h00, frz}, 8'h00);
  endtask : t_misc
  // Link clock runs eight cycles to gather the byte, mostly before its frame starts, and rests low after them
  task automatic t_serial;
    host.wr(OFS_CHAR_CTL, 8'h03);
    host.wr(OFS_CLK_VOL, 8'h03);
    #7.3;
    fork
      frame({3'b111, SER, 1'b0}, 10);
      for (int k = 0; k < 8; k++)
      begin
        txd = SER[k];
        #8 xclk = 1'b1;
        #24 chk({7'h00, tclk}, 8'h01);
        #8 xclk = 1'b0;
        #24 chk({7'h00, tclk}, 8'h00);
      end
    join
    txd = ~SER[7];
  endtask : t_serial

  initial
  begin
    rst_n = 1'b0;
    xclk = 1'b0;
    txd = 1'b1;
    ones = 1'b0;
    hdx = 1'b0;
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    t_regs;
    t_ram(0);
    t_ram(1);
    t_clk;
    t_tx;
    t_voice;
    t_misc;
    t_serial;
    test_done;
  end
  initial
  begin
    #100000;
    num_errors++;
    test_done;
  end
endmodule : testbench
